// ---- verilog/tlic_ctrl.sv ----
// Two-level interrupt controller: registers, arbitration and vectoring.
//
// Functional notes
// - The primary priority register sits at B8H, resets to 00H and is bit addressable.
// - Its bits 6..0 give converter, timer 2, UART, timer 1, ext 1, timer 0, ext 0 level, one high.
// - The secondary register sits at A9H, resets to A0H and has no bit addressing.
// - Secondary bits 6, 5, 4 set interval counter, supply monitor and serial levels.
// - Secondary bits 2, 1, 0 enable interval counter, supply monitor and serial requests.
// - Bit 7 of primary priority and secondary registers holds nothing and ignores writes.
// - An enabled high-level request preempts a running low-level routine.
// - When both levels request together the high-level one is vectored first.
// - A routine is never preempted by a request of its own level.
// - Same-level requests are served in the fixed polling order.
// - Taking a request pushes the program counter, then loads the vector.
// - Each source has its own fixed vector address.
// - Bit 7 of the primary enable register gates every source.
`timescale 1ns/100ps
module tlic_ctrl #(
   parameter int NSRC = 11
) (
   input  wire logic            mclk,
   input  wire logic            nrst,
   // Special function register port of the core.
   input  wire logic [7:0]      sfrAddr,
   input  wire logic [7:0]      sfrWrData,
   input  wire logic            sfrWr,
   input  wire logic            sfrRd,
   output logic [7:0]           sfrRdData_r,
   output logic                 sfrHit_r,
   // Single-bit write port of the core.
   input  wire logic [7:0]      bitAddr,
   input  wire logic            bitVal,
   input  wire logic            bitWr,
   // Source requests, index in vector order.
   input  wire logic [NSRC-1:0] srcReq,
   // Core sequencing.
   input  wire logic            intAllow,
   input  wire logic            retiDone,
   output logic                 pushPc_r,
   output logic                 loadPc_r,
   output logic [15:0]          vector_r,
   output logic [NSRC-1:0]      srcAck_r,
   output logic [1:0]           activeLvl_r
);

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [7:0] enReg_r;
   logic [7:0] enReg_nxt;
   logic [6:0] prioReg_r;
   logic [6:0] prioReg_nxt;
   logic [6:0] secReg_r;
   logic [6:0] secReg_nxt;
   logic [7:0] rdData_nxt;
   logic       hit_nxt;

   // Byte writes, single-bit writes and reads; bit 7 of two registers has no storage.
   always_comb begin
      enReg_nxt   = enReg_r;
      prioReg_nxt = prioReg_r;
      secReg_nxt  = secReg_r;
      rdData_nxt  = 8'h00;
      hit_nxt     = 1'b0;
      if (sfrWr) begin
         unique case (sfrAddr)
            tlic_pkg::ADDR_PRI_ENABLE: enReg_nxt = sfrWrData;
            tlic_pkg::ADDR_PRI_PRIO:   prioReg_nxt = sfrWrData[6:0];
            tlic_pkg::ADDR_SEC_IRQ:    secReg_nxt = sfrWrData[6:0];
            default: ;
         endcase
      end
      // The secondary register decodes no bit address, so only two bases respond.
      if (bitWr) begin
         if (bitAddr[7:3] == tlic_pkg::ADDR_PRI_ENABLE[7:3]) begin
            enReg_nxt[bitAddr[2:0]] = bitVal;
         end else if (bitAddr[7:3] == tlic_pkg::ADDR_PRI_PRIO[7:3] &&
                      bitAddr[2:0] != 3'(tlic_pkg::NO_STORE_BIT)) begin
            prioReg_nxt[bitAddr[2:0]] = bitVal;
         end
      end
      if (sfrRd) begin
         unique case (sfrAddr)
            tlic_pkg::ADDR_PRI_ENABLE: begin
               rdData_nxt = enReg_r;
               hit_nxt    = 1'b1;
            end
            tlic_pkg::ADDR_PRI_PRIO: begin
               rdData_nxt = {1'b0, prioReg_r};
               hit_nxt    = 1'b1;
            end
            tlic_pkg::ADDR_SEC_IRQ: begin
               rdData_nxt = {tlic_pkg::RST_SEC_IRQ[7], secReg_r};
               hit_nxt    = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // Register storage; unmapped reads answer zero with the hit flag low.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         enReg_r     <= tlic_pkg::RST_PRI_ENABLE;
         prioReg_r   <= tlic_pkg::RST_PRI_PRIO[6:0];
         secReg_r    <= tlic_pkg::RST_SEC_IRQ[6:0];
         sfrRdData_r <= 8'h00;
         sfrHit_r    <= 1'b0;
      end else begin
         enReg_r     <= enReg_nxt;
         prioReg_r   <= prioReg_nxt;
         secReg_r    <= secReg_nxt;
         sfrRdData_r <= rdData_nxt;
         sfrHit_r    <= hit_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Request qualification and per-level polling
   // ------------------------------------------------------------------
   logic [NSRC-1:0] srcEn;
   logic [NSRC-1:0] srcHigh;
   logic [1:0][NSRC-1:0] lvlReq;
   logic [1:0]      lvlFound;
   logic [1:0][3:0] lvlIdx;

   // Map register bits onto sources; the global gate stops everything.
   always_comb begin
      srcEn   = {1'b1, secReg_r[tlic_pkg::SEC_EN_LSB + 2],
                 secReg_r[tlic_pkg::SEC_EN_LSB + 1], secReg_r[tlic_pkg::SEC_EN_LSB],
                 enReg_r[6:0]};
      srcHigh = {tlic_pkg::WATCHDOG_HIGH, secReg_r[tlic_pkg::SEC_PRIO_LSB + 2],
                 secReg_r[tlic_pkg::SEC_PRIO_LSB + 1], secReg_r[tlic_pkg::SEC_PRIO_LSB],
                 prioReg_r};
      lvlReq[1] = srcReq & srcEn & srcHigh & {NSRC{enReg_r[tlic_pkg::GATE_BIT]}};
      lvlReq[0] = srcReq & srcEn & ~srcHigh & {NSRC{enReg_r[tlic_pkg::GATE_BIT]}};
   end

   // One polling chain per level.
   for (genvar l = 0; l < 2; l++) begin : g_level
      tlic_poll #(
         .N      (NSRC)
      ) u_poll (
         .req    (lvlReq[l]),
         .found  (lvlFound[l]),
         .winIdx (lvlIdx[l])
      );
   end

   // ------------------------------------------------------------------
   // Vectoring sequencer and active-level tracking
   // ------------------------------------------------------------------
   tlic_pkg::tlic_seq_t state_r;
   tlic_pkg::tlic_seq_t state_nxt;
   logic            lvl_r;
   logic            lvl_nxt;
   logic [3:0]      winIdx_r;
   logic [3:0]      winIdx_nxt;
   logic            pushPc_nxt;
   logic            loadPc_nxt;
   logic [15:0]     vector_nxt;
   logic [NSRC-1:0] srcAck_nxt;
   logic [1:0]      activeLvl_nxt;
   logic            takeHigh;
   logic            takeLow;

   // High wins over low; a level is taken only when no routine of it or above runs.
   always_comb begin
      takeHigh      = lvlFound[1] && !activeLvl_r[1];
      takeLow       = lvlFound[0] && activeLvl_r == 2'b00 && !lvlFound[1];
      state_nxt     = state_r;
      lvl_nxt       = lvl_r;
      winIdx_nxt    = winIdx_r;
      pushPc_nxt    = 1'b0;
      loadPc_nxt    = 1'b0;
      vector_nxt    = vector_r;
      srcAck_nxt    = '0;
      activeLvl_nxt = activeLvl_r;
      // Return releases the highest level in service first, since levels nest.
      if (retiDone) begin
         if (activeLvl_r[1]) begin
            activeLvl_nxt[1] = 1'b0;
         end else begin
            activeLvl_nxt[0] = 1'b0;
         end
      end
      unique case (state_r)
         tlic_pkg::SEQ_IDLE: begin
            if (intAllow && (takeHigh || takeLow)) begin
               lvl_nxt    = takeHigh;
               winIdx_nxt = takeHigh ? lvlIdx[1] : lvlIdx[0];
               pushPc_nxt = 1'b1;
               state_nxt  = tlic_pkg::SEQ_PUSH;
            end
         end
         tlic_pkg::SEQ_PUSH: begin
            loadPc_nxt             = 1'b1;
            vector_nxt             = tlic_pkg::VECTOR_TABLE[winIdx_r];
            srcAck_nxt[winIdx_r]   = 1'b1;
            activeLvl_nxt[lvl_r]   = 1'b1;
            state_nxt              = tlic_pkg::SEQ_LOAD;
         end
         tlic_pkg::SEQ_LOAD: begin
            state_nxt = tlic_pkg::SEQ_IDLE;
         end
         default: begin
            state_nxt = tlic_pkg::SEQ_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r     <= tlic_pkg::SEQ_IDLE;
         lvl_r       <= 1'b0;
         winIdx_r    <= 4'h0;
         pushPc_r    <= 1'b0;
         loadPc_r    <= 1'b0;
         vector_r    <= 16'h0000;
         srcAck_r    <= '0;
         activeLvl_r <= 2'b00;
      end else begin
         state_r     <= state_nxt;
         lvl_r       <= lvl_nxt;
         winIdx_r    <= winIdx_nxt;
         pushPc_r    <= pushPc_nxt;
         loadPc_r    <= loadPc_nxt;
         vector_r    <= vector_nxt;
         srcAck_r    <= srcAck_nxt;
         activeLvl_r <= activeLvl_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   push_then_load_a: assert property (@(posedge mclk) disable iff (!nrst)
      pushPc_r |=> loadPc_r && !pushPc_r)
      else $error("vector load did not follow the push");

   load_after_push_a: assert property (@(posedge mclk) disable iff (!nrst)
      loadPc_r |-> $past(pushPc_r))
      else $error("vector loaded without a push");

   vector_value_a: assert property (@(posedge mclk) disable iff (!nrst)
      loadPc_r |-> vector_r == tlic_pkg::VECTOR_TABLE[winIdx_r] && srcAck_r[winIdx_r])
      else $error("wrong vector for the winning source");

   gate_closed_a: assert property (@(posedge mclk) disable iff (!nrst)
      pushPc_r |-> $past(enReg_r[tlic_pkg::GATE_BIT]))
      else $error("request taken while the global gate was closed");

   same_level_a: assert property (@(posedge mclk) disable iff (!nrst)
      pushPc_r |-> !activeLvl_r[lvl_r] && !(activeLvl_r[1] && !lvl_r))
      else $error("routine preempted by an equal or lower level");

   high_first_a: assert property (@(posedge mclk) disable iff (!nrst)
      pushPc_r && $past(lvlFound[1]) |-> lvl_r)
      else $error("low level chosen while a high request waited");

   preempt_low_a: assert property (@(posedge mclk) disable iff (!nrst)
      state_r == tlic_pkg::SEQ_IDLE && intAllow && lvlFound[1] && activeLvl_r == 2'b01
      |=> pushPc_r && lvl_r)
      else $error("high request failed to preempt a low routine");

   prio_bit7_a: assert property (@(posedge mclk) disable iff (!nrst)
      $past(sfrRd) && $past(sfrAddr) == tlic_pkg::ADDR_PRI_PRIO |-> !sfrRdData_r[7])
      else $error("primary priority bit 7 read back as one");

   reti_release_a: assert property (@(posedge mclk) disable iff (!nrst)
      retiDone && activeLvl_r[1] && state_r != tlic_pkg::SEQ_PUSH |=> !activeLvl_r[1])
      else $error("return did not release the high level");

   watchdog_first_a: assert property (@(posedge mclk) disable iff (!nrst)
      pushPc_r && $past(lvlReq[1][tlic_pkg::SRC_WATCHDOG]) && lvl_r
      |-> winIdx_r != tlic_pkg::SRC_EXT0)
      else $error("external 0 served ahead of the watchdog");

endmodule // tlic_ctrl

// ---- verilog/tlic_pkg.sv ----
// Constants shared by the two-level interrupt controller files.
package tlic_pkg;

   // ------------------------------------------------------------------
   // Special function addresses and power-on values
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PRI_ENABLE = 8'hA8;
   localparam logic [7:0] ADDR_SEC_IRQ    = 8'hA9;
   localparam logic [7:0] ADDR_PRI_PRIO   = 8'hB8;
   localparam logic [7:0] RST_PRI_ENABLE  = 8'h00;
   localparam logic [7:0] RST_SEC_IRQ     = 8'hA0;
   localparam logic [7:0] RST_PRI_PRIO    = 8'h00;

   // Field positions.
   localparam int GATE_BIT      = 7;
   localparam int SEC_PRIO_LSB  = 4;
   localparam int SEC_EN_LSB    = 0;
   localparam int NO_STORE_BIT  = 7;

   // ------------------------------------------------------------------
   // Sources, indexed in vector order
   // ------------------------------------------------------------------
   localparam int NUM_SRC = 11;
   localparam logic [3:0] SRC_EXT0     = 4'h0;
   localparam logic [3:0] SRC_TIMER0   = 4'h1;
   localparam logic [3:0] SRC_EXT1     = 4'h2;
   localparam logic [3:0] SRC_TIMER1   = 4'h3;
   localparam logic [3:0] SRC_UART     = 4'h4;
   localparam logic [3:0] SRC_TIMER2   = 4'h5;
   localparam logic [3:0] SRC_CONV     = 4'h6;
   localparam logic [3:0] SRC_SERIAL   = 4'h7;
   localparam logic [3:0] SRC_SUPPLY   = 4'h8;
   localparam logic [3:0] SRC_INTERVAL = 4'h9;
   localparam logic [3:0] SRC_WATCHDOG = 4'hA;

   // Vector address per source; element i belongs to source index i.
   localparam logic [10:0][15:0] VECTOR_TABLE = {
      16'h005B, 16'h0053, 16'h0043, 16'h003B, 16'h0033, 16'h002B,
      16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

   // Polling order within one level; element 0 is polled first.
   localparam logic [10:0][3:0] POLL_ORDER = {
      SRC_INTERVAL, SRC_TIMER2, SRC_UART, SRC_SERIAL, SRC_TIMER1, SRC_EXT1,
      SRC_TIMER0, SRC_CONV, SRC_EXT0, SRC_WATCHDOG, SRC_SUPPLY};

   // Level of the watchdog source, which has no priority bit of its own.
   localparam logic WATCHDOG_HIGH = 1'b1;

   // Sequencer states.
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_PUSH = 2'b01,
      SEQ_LOAD = 2'b10
   } tlic_seq_t;

endpackage

// ---- verilog/tlic_poll.sv ----
// Fixed-order polling of the requests of one priority level.
`timescale 1ns/100ps
module tlic_poll #(
   parameter int N = 11
) (
   input  wire logic [N-1:0] req,
   output logic              found,
   output logic [3:0]        winIdx
);

   // ------------------------------------------------------------------
   // Poll from the last position backwards so the earliest position wins
   // ------------------------------------------------------------------
   always_comb begin
      found  = 1'b0;
      winIdx = 4'h0;
      for (int k = N - 1; k >= 0; k--) begin
         if (req[tlic_pkg::POLL_ORDER[k]]) begin
            found  = 1'b1;
            winIdx = tlic_pkg::POLL_ORDER[k];
         end
      end
   end

endmodule // tlic_poll

// ---- tb/tlic_core_model.sv ----
// Behavioural core and peripheral side facing the interrupt controller.
`timescale 1ns/100ps
module tlic_core_model (
   input  wire logic        mclk,
   input  wire logic [10:0] srcAck_r,
   output logic [10:0]      srcReq,
   output logic             intAllow,
   output logic             retiDone
);
   // Everything starts quiet; the bench stalls the core by lowering intAllow.
   initial begin
      srcReq = 11'h000;
      intAllow = 1'b1;
      retiDone = 1'b0;
   end

   // A peripheral holds its flag until the controller acknowledges it.
   always @(posedge mclk) begin
      srcReq <= srcReq & ~srcAck_r;
   end

   // Raises request flags just after a falling edge.
   task automatic post(input logic [10:0] m);
      @(negedge mclk);
      srcReq = srcReq | m;
   endtask

   // Ends a routine after lag cycles; a long lag models a slow handler.
   task automatic reti(input int lag);
      repeat (lag) @(negedge mclk);
      retiDone = 1'b1;
      @(negedge mclk);
      retiDone = 1'b0;
   endtask
endmodule // tlic_core_model

// ---- tb/tlic_ctrl_tb.sv ----
// Self-checking testbench of the two-level interrupt controller.
`timescale 1ns/100ps
module tlic_ctrl_tb;
   logic        mclk;
   logic        nrst;
   logic [7:0]  sfrAddr;
   logic [7:0]  sfrWrData;
   logic        sfrWr;
   logic        sfrRd;
   logic [7:0]  sfrRdData_r;
   logic        sfrHit_r;
   logic [7:0]  bitAddr;
   logic        bitVal;
   logic        bitWr;
   logic [10:0] srcReq;
   logic        intAllow;
   logic        retiDone;
   logic        pushPc_r;
   logic        loadPc_r;
   logic [15:0] vector_r;
   logic [10:0] srcAck_r;
   logic [1:0]  activeLvl_r;
   logic        lastPush;
   logic [31:0] rnd;
   int          err_total;
   int          num_checks;
   int          mA8;
   int          mA9;
   int          mB8;
   int          mReq;
   int          act;
   int          pollOrd [11] = '{8, 10, 0, 6, 1, 2, 3, 7, 4, 5, 9};
   int          vecTab [12] = '{3, 11, 19, 27, 35, 43, 51, 59, 67, 83, 91, 0};

   tlic_ctrl DUT (.mclk(mclk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
      .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData_r(sfrRdData_r), .sfrHit_r(sfrHit_r),
      .bitAddr(bitAddr), .bitVal(bitVal), .bitWr(bitWr), .srcReq(srcReq),
      .intAllow(intAllow), .retiDone(retiDone), .pushPc_r(pushPc_r), .loadPc_r(loadPc_r),
      .vector_r(vector_r), .srcAck_r(srcAck_r), .activeLvl_r(activeLvl_r));
   tlic_core_model cm (.mclk(mclk), .srcAck_r(srcAck_r), .srcReq(srcReq),
      .intAllow(intAllow), .retiDone(retiDone));

   // One push pulse must sit just before each load pulse.
   always @(posedge mclk) lastPush <= pushPc_r;
   always #5 mclk = ~mclk;

   // --------------------------------------------------------------
   // Reference model
   // --------------------------------------------------------------
   // Level per source index; the watchdog is always high.
   function automatic int levels();
      return (1 << 10) | (((mA9 >> 4) & 7) << 7) | (mB8 & 127);
   endfunction

   // Enable per source, all of it behind the global gate.
   function automatic int enables();
      if (((mA8 >> 7) & 1) == 0) return 0;
      return (1 << 10) | ((mA9 & 7) << 7) | (mA8 & 127);
   endfunction

   // Next source to be vectored, or -1 when everything must wait.
   function automatic int pick(input int r);
      int lv;
      int q;
      int s;
      lv = levels();
      q = r & enables();
      for (int h = 1; h >= 0; h--) begin
         for (int k = 0; k < 11; k++) begin
            s = pollOrd[k];
            if (((q >> s) & 1) == 1 && ((lv >> s) & 1) == h) begin
               if (h == 1 ? (act & 2) == 0 : act == 0) return s;
               return -1;
            end
         end
      end
      return -1;
   endfunction

   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction

   // --------------------------------------------------------------
   // Driver and comparison tasks
   // --------------------------------------------------------------
   task automatic check(input string nm, input int exp, input logic [15:0] got);
      num_checks++;
      if (got !== 16'(exp)) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, 16'(exp), got);
      end
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfrAddr = a;
      sfrWrData = d;
      sfrWr = 1'b1;
      @(negedge mclk);
      sfrWr = 1'b0;
      if (a == 8'hA8) mA8 = d;
      if (a == 8'hA9) mA9 = d | 8'h80;
      if (a == 8'hB8) mB8 = d & 8'h7F;
   endtask

   task automatic sfr_rd(input logic [7:0] a);
      int hit;
      hit = (a == 8'hA8 || a == 8'hA9 || a == 8'hB8) ? 1 : 0;
      @(negedge mclk);
      sfrAddr = a;
      sfrRd = 1'b1;
      @(negedge mclk);
      sfrRd = 1'b0;
      check("rdata", a == 8'hA8 ? mA8 : a == 8'hA9 ? mA9 : a == 8'hB8 ? mB8 : 0,
            {8'h00, sfrRdData_r});
      check("hit", hit, {15'h0000, sfrHit_r});
   endtask

   // Single-bit writes are mirrored for the enable and primary priority bytes.
   task automatic bit_wr(input logic [7:0] a, input logic v);
      @(negedge mclk);
      bitAddr = a;
      bitVal = v;
      bitWr = 1'b1;
      @(negedge mclk);
      bitWr = 1'b0;
      if (a[7:3] == 5'h15) mA8 = v ? mA8 | (1 << a[2:0]) : mA8 & ~(1 << a[2:0]);
      if (a[7:3] == 5'h17) mB8 = (v ? mB8 | (1 << a[2:0]) : mB8 & ~(1 << a[2:0])) & 127;
   endtask

   task automatic reti(input int lag);
      cm.reti(lag);
      act = ((act & 2) != 0) ? (act & 1) : 0;
   endtask

   task automatic post(input int m);
      cm.post(11'(m));
      mReq = mReq | m;
   endtask

   // Waits for one vectoring sequence; a negative lag leaves the routine open.
   task automatic serve(input int lag);
      int w;
      int n;
      w = pick(mReq);
      w = (w < 0) ? 11 : w;
      n = 0;
      while (loadPc_r !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      check("load", 1, {15'h0000, loadPc_r});
      check("push", 1, {15'h0000, lastPush});
      check("vector", vecTab[w], vector_r);
      check("ack", 1 << w, {5'h00, srcAck_r});
      act = act | ((((levels() >> w) & 1) == 1) ? 2 : 1);
      check("level", act, {14'h0000, activeLvl_r});
      mReq = mReq & ~(1 << w);
      if (lag >= 0) reti(lag);
   endtask

   task automatic quiet(input int n);
      int seen;
      seen = 0;
      repeat (n) begin
         @(negedge mclk);
         if (pushPc_r !== 1'b0) seen++;
      end
      check("idle", 0, 16'(seen));
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Whole run is well under a thousand cycles; this limit only catches a hang.
   initial begin
      #300us;
      err_total++;
      results();
   end

   // --------------------------------------------------------------
   // Test sequence
   // --------------------------------------------------------------
   initial begin
      {mclk, nrst, sfrWr, sfrRd, bitWr, bitVal} = 6'h00;
      {sfrAddr, sfrWrData, bitAddr} = 24'h0000_00;
      {err_total, num_checks, mA8, mB8, mReq, act} = 192'h0;
      mA9 = 8'hA0;
      rnd = 32'd99570;
      repeat (10) @(negedge mclk);
      nrst = 1'b1;
      sfr_rd(8'hA8);
      sfr_rd(8'hA9);
      sfr_rd(8'hB8);
      sfr_rd(8'hB9);
      sfr_wr(8'hB8, 8'hFF);
      sfr_rd(8'hB8);
      sfr_wr(8'hA9, 8'h77);
      sfr_rd(8'hA9);
      bit_wr(8'hBA, 1'b0);
      sfr_rd(8'hB8);
      $display("test registers done");
      sfr_wr(8'hB8, 8'h00);
      sfr_wr(8'hA9, 8'h07);
      sfr_wr(8'hA8, 8'hFF);
      post(11'h7FF);
      for (int k = 0; k < 11; k++) serve(k % 3);
      $display("test polling done");
      sfr_wr(8'hA8, 8'h7F);
      sfr_wr(8'hA9, 8'h06);
      post(11'h081);
      quiet(20);
      cm.intAllow = 1'b0;
      bit_wr(8'hAF, 1'b1);
      quiet(10);
      cm.intAllow = 1'b1;
      serve(0);
      quiet(15);
      sfr_wr(8'hA9, 8'h07);
      serve(0);
      $display("test gating done");
      sfr_wr(8'hB8, 8'h02);
      post(11'h001);
      serve(-1);
      post(11'h002);
      serve(-1);
      sfr_wr(8'hB8, 8'h0A);
      post(11'h00C);
      quiet(20);
      reti(1);
      serve(-1);
      reti(0);
      quiet(15);
      reti(2);
      serve(0);
      $display("test preemption done");
      repeat (6) begin
         sfr_wr(8'hB8, 8'(xs()));
         sfr_wr(8'hA9, 8'(xs()) & 8'h77);
         sfr_wr(8'hA8, 8'(xs()) | 8'h80);
         post(xs() & 11'h7FF);
         while (pick(mReq) >= 0) serve(rnd % 3);
         sfr_wr(8'hA8, 8'h00);
         sfr_wr(8'hA9, 8'h07);
         sfr_wr(8'hA8, 8'hFF);
         while (pick(mReq) >= 0) serve(0);
      end
      $display("test random done");
      // A reset in mid-run must drop an open routine and restore every register.
      post(11'h001);
      serve(-1);
      nrst = 1'b0;
      @(negedge mclk);
      check("reset level", 0, {14'h0000, activeLvl_r});
      nrst = 1'b1;
      mA8 = 0;
      mB8 = 0;
      mA9 = 8'hA0;
      act = 0;
      sfr_rd(8'hA8);
      sfr_rd(8'hA9);
      sfr_rd(8'hB8);
      $display("test reset done");
      results();
   end
endmodule // tlic_ctrl_tb
